// ### vfd_scan_pkg.sv
// Constants and types shared by the display scan and its slot timer.
// Assumes a single 10 MHz clock; all times below are turned into cycles here.
package vfd_scan_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and scan timing
    localparam int CLK_PERIOD_NS = 100;         // 10 MHz system clock
    localparam int FRAME_PERIOD_NS = 1778000;   // Full scan period, 1.778 ms
    localparam int SLOTS_PER_FRAME = 10;        // 1/10 duty per digit
    // Longest-time figures round down to whole cycles
    localparam int FRAME_CYC = FRAME_PERIOD_NS / CLK_PERIOD_NS;
    localparam int SLOT_CYC = FRAME_CYC / SLOTS_PER_FRAME;
    localparam int SLOT_CNT_W = 11;             // Holds SLOT_CYC - 1
    localparam logic [SLOT_CNT_W-1:0] SLOT_CNT_LAST = SLOT_CNT_W'(SLOT_CYC - 1);
    localparam logic [SLOT_CNT_W-1:0] SLOT_CNT_RST = 11'h000;

    ////////////////////////////////////////////////////////////////////////////
    // Slot index and widths
    localparam int SLOT_IDX_W = 4;
    localparam logic [SLOT_IDX_W-1:0] SLOT_IDX_RST = 4'h0;
    localparam logic [SLOT_IDX_W-1:0] SLOT_IDX_LAST = 4'h9;
    localparam int DIGIT_COUNT = 7;             // Seven digit strobes
    localparam logic [SLOT_IDX_W-1:0] DIGIT_SLOTS = 4'h7;
    localparam int DIGIT_SEL_W = 3;
    localparam int SEGMENT_COUNT = 8;           // Segments a..h
    localparam int KEY_WIDTH = 4;               // Key return lines
    localparam int MEM_ADDR_W = 7;              // 128-word data memory

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [DIGIT_COUNT-1:0] STROBE_RST = 7'h00;
    localparam logic [SEGMENT_COUNT-1:0] SEGMENT_RST = 8'h00;
    localparam logic [KEY_WIDTH-1:0] KEY_LATCH_RST = 4'h0;
    localparam logic [MEM_ADDR_W-1:0] MEM_ADDR_RST = 7'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Scan state
    typedef enum logic [1:0]
    {
        SCAN_HOLD = 2'b00,                      // Reset or clock halt, all dark
        SCAN_RUN = 2'b01                        // Strobes cycling
    } scan_state_t;

endpackage : vfd_scan_pkg

// ### vfd_slot_timer.sv
// Slot timer: divides the system clock into display slots of one tenth frame.
// Assumes run is low while the scan must stand still; the count restarts then.
`timescale 1ns/10ps
module vfd_slot_timer
    import vfd_scan_pkg::*;
(
    // Clock and synchronised reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic run,
    // Slot position
    output logic [SLOT_IDX_W-1:0] slot_idx_ff,
    output logic slot_end
);

    logic [SLOT_CNT_W-1:0] cnt_ff;              // Cycles within the slot

    // Last cycle of a slot, one-cycle enable pulse
    assign slot_end = run && (cnt_ff == SLOT_CNT_LAST);

    ////////////////////////////////////////////////////////////////////////////
    // Cycle counter inside a slot
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_ff <= SLOT_CNT_RST;
        end
        else if (!run || slot_end)
        begin
            // Halt restarts the slot so the first slot after it is whole
            cnt_ff <= SLOT_CNT_RST;
        end
        else
        begin
            cnt_ff <= cnt_ff + 11'h001;
        end
    end

    // Slot index walks 0..9 and wraps
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            slot_idx_ff <= SLOT_IDX_RST;
        end
        else if (!run)
        begin
            slot_idx_ff <= SLOT_IDX_RST;
        end
        else if (slot_end)
        begin
            slot_idx_ff <= (slot_idx_ff == SLOT_IDX_LAST) ? SLOT_IDX_RST
                                                          : slot_idx_ff + 4'h1;
        end
    end

endmodule : vfd_slot_timer

// ### vfd_digit_key_scan.sv
// Dynamic digit/segment scan for a seven-digit display with shared key matrix.
// Assumes key lines and program-side strobes are synchronous to clk.
`timescale 1ns/10ps

// Behaviour
// RL1: Each strobe 1/10 duty, 1.778 ms frame
// RL2: Seven digit strobes, eight segment drives
// RL3: Strobes low during reset and clock halt
// RL4: Latch key lines at program-chosen digit
// RL5: Key read writes latch to memory
// RL6: Strobes time the key matrix returns
// RL7: Reset held while low, scan restarts after
// RL8: Digits one per slot, three blank slots
module vfd_digit_key_scan
    import vfd_scan_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Clock stop instruction in effect
    input wire logic clock_halt_op,
    // Segment pattern writes from the program
    input wire logic seg_wr_en,
    input wire logic [DIGIT_SEL_W-1:0] seg_wr_digit,
    input wire logic [SEGMENT_COUNT-1:0] seg_wr_data,
    // Key matrix
    input wire logic [KEY_WIDTH-1:0] key_return_in,
    input wire logic [DIGIT_SEL_W-1:0] key_slot_sel,
    // Key-read instruction
    input wire logic key_read_req,
    input wire logic [MEM_ADDR_W-1:0] key_read_addr,
    // Data memory write port
    output logic mem_wr_en,
    output logic [MEM_ADDR_W-1:0] mem_wr_addr,
    output logic [KEY_WIDTH-1:0] mem_wr_data,
    // Display drive
    output logic [DIGIT_COUNT-1:0] digit_strobe_out,
    output logic [SEGMENT_COUNT-1:0] segment_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    logic rst_meta_ff;                          // First stage, read only by next
    logic rst_n;                                // Released copy used everywhere

    // Assert at once, release through two flops
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta_ff <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_n <= rst_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Scan state
    scan_state_t state_ff;
    scan_state_t nxt_state;
    logic run;                                  // Timer advances
    logic [SLOT_IDX_W-1:0] slot_idx;            // Current slot 0..9
    logic slot_end;                             // Last cycle of slot

    // Halt wins; leaving it starts again from slot 0
    always_comb
    begin
        case (state_ff)
            SCAN_HOLD: nxt_state = clock_halt_op ? SCAN_HOLD : SCAN_RUN;
            SCAN_RUN: nxt_state = clock_halt_op ? SCAN_HOLD : SCAN_RUN;
            default: nxt_state = SCAN_HOLD;
        endcase
    end

    // State register, held dark through reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= SCAN_HOLD;              // [RL7]
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign run = (state_ff == SCAN_RUN) && !clock_halt_op;

    vfd_slot_timer u_slot_timer
    (
        .clk(clk),
        .rst_n(rst_n),
        .run(run),
        .slot_idx_ff(slot_idx),
        .slot_end(slot_end)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Digit strobes
    logic [DIGIT_COUNT-1:0] strobe_ff;
    logic [DIGIT_COUNT-1:0] nxt_strobe;

    // One digit per slot; slots 7..9 blank, which sets the 1/10 duty
    always_comb
    begin
        nxt_strobe = STROBE_RST;
        if (run && (slot_idx < DIGIT_SLOTS))
        begin
            nxt_strobe[slot_idx[DIGIT_SEL_W-1:0]] = 1'b1; // [RL8] [RL1]
        end
    end

    // Strobe outputs come from flops; reset and halt force them low
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strobe_ff <= STROBE_RST;            // [RL3]
        end
        else
        begin
            strobe_ff <= nxt_strobe;            // [RL3] [RL2]
        end
    end

    assign digit_strobe_out = strobe_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Segment pattern store, one entry per digit
    logic [SEGMENT_COUNT-1:0] seg_mem_ff [DIGIT_COUNT];
    logic [SEGMENT_COUNT-1:0] seg_ff;           // Segment drive flops

    genvar gi;
    generate
        for (gi = 0; gi < DIGIT_COUNT; gi++)
        begin : g_seg_entry
            // Each entry keeps its pattern until rewritten
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    seg_mem_ff[gi] <= SEGMENT_RST;
                end
                else if (seg_wr_en && (seg_wr_digit == DIGIT_SEL_W'(gi)))
                begin
                    seg_mem_ff[gi] <= seg_wr_data;
                end
            end
        end
    endgenerate

    // Segments change with the strobe so no ghosting into the next digit
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            seg_ff <= SEGMENT_RST;
        end
        else if (run && (slot_idx < DIGIT_SLOTS))
        begin
            seg_ff <= seg_mem_ff[slot_idx[DIGIT_SEL_W-1:0]]; // [RL2]
        end
        else
        begin
            seg_ff <= SEGMENT_RST;              // Blank slots and halt
        end
    end

    assign segment_out = seg_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Key input latch
    logic [KEY_WIDTH-1:0] key_latch_ff;
    logic key_capture;                          // Sample point this cycle

    // Sample at the end of the chosen slot, when returns have settled
    assign key_capture = slot_end && (slot_idx == SLOT_IDX_W'(key_slot_sel)) &&
                         (slot_idx < DIGIT_SLOTS); // [RL6]

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            key_latch_ff <= KEY_LATCH_RST;
        end
        else if (key_capture)
        begin
            key_latch_ff <= key_return_in;      // [RL4]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Key-read transfer to data memory
    logic mem_wr_en_ff;
    logic [MEM_ADDR_W-1:0] mem_wr_addr_ff;
    logic [KEY_WIDTH-1:0] mem_wr_data_ff;

    // One write cycle after each request; holds the latch as it stood
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem_wr_en_ff <= 1'b0;
            mem_wr_addr_ff <= MEM_ADDR_RST;
            mem_wr_data_ff <= KEY_LATCH_RST;
        end
        else
        begin
            mem_wr_en_ff <= key_read_req;       // [RL5]
            if (key_read_req)
            begin
                mem_wr_addr_ff <= key_read_addr;
                mem_wr_data_ff <= key_latch_ff; // [RL5]
            end
        end
    end

    assign mem_wr_en = mem_wr_en_ff;
    assign mem_wr_addr = mem_wr_addr_ff;
    assign mem_wr_data = mem_wr_data_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Check helpers: strobe 0 high time and period
    logic s0_q_ff;                              // Strobe 0 one cycle back
    logic seen_ff;                              // Clean rise since halt
    logic [15:0] hi_cnt_ff;                     // Cycles since rise, while high
    logic [15:0] per_cnt_ff;                    // Cycles since last rise

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s0_q_ff <= 1'b0;
            seen_ff <= 1'b0;
            hi_cnt_ff <= 16'h0000;
            per_cnt_ff <= 16'h0000;
        end
        else
        begin
            s0_q_ff <= strobe_ff[0];
            hi_cnt_ff <= strobe_ff[0] ? hi_cnt_ff + 16'h0001 : 16'h0000;
            per_cnt_ff <= (strobe_ff[0] && !s0_q_ff) ? 16'h0001 : per_cnt_ff + 16'h0001;
            if (clock_halt_op)
            begin
                seen_ff <= 1'b0;
            end
            else if (strobe_ff[0] && !s0_q_ff)
            begin
                seen_ff <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    a_strobe_high_time: assert property (@(posedge clk) disable iff (!rst_n) // [RL1]
        (!strobe_ff[0] && s0_q_ff && seen_ff) |-> (hi_cnt_ff == 16'(SLOT_CYC)))
        else $error("digit strobe high time is not one slot");
    a_frame_period: assert property (@(posedge clk) disable iff (!rst_n) // [RL1]
        (strobe_ff[0] && !s0_q_ff && seen_ff) |-> (per_cnt_ff == 16'(FRAME_CYC)))
        else $error("scan frame period wrong");
    a_strobe_one_hot: assert property (@(posedge clk) disable iff (!rst_n) // [RL8]
        $onehot0(digit_strobe_out))
        else $error("more than one digit strobe active");
    a_strobe_tracks_slot: assert property (@(posedge clk) disable iff (!rst_n) // [RL6]
        (run && slot_idx < DIGIT_SLOTS) |=>
        (digit_strobe_out == (7'h01 << $past(slot_idx))))
        else $error("strobe does not match slot");
    a_blank_slots: assert property (@(posedge clk) disable iff (!rst_n) // [RL2]
        (slot_idx >= DIGIT_SLOTS) |=> (digit_strobe_out == 7'h00 && segment_out == 8'h00))
        else $error("display not blank in spare slot");
    a_halt_dark: assert property (@(posedge clk) disable iff (!rst_n) // [RL3]
        clock_halt_op |=> (digit_strobe_out == 7'h00) [*2])
        else $error("strobe active during clock halt");
    a_reset_dark: assert property (@(posedge clk) disable iff (!arst_n) // [RL3]
        !rst_n |-> (digit_strobe_out == 7'h00 && state_ff == SCAN_HOLD))
        else $error("strobe active during reset");
    a_restart_scan: assert property (@(posedge clk) disable iff (!arst_n) // [RL7]
        ($rose(rst_n) && !clock_halt_op) |=> ##1 (digit_strobe_out == 7'h01))
        else $error("scan did not restart at digit 0");
    a_key_capture: assert property (@(posedge clk) disable iff (!rst_n) // [RL4]
        key_capture |=> (key_latch_ff == $past(key_return_in)))
        else $error("key latch missed capture");
    a_key_read: assert property (@(posedge clk) disable iff (!rst_n) // [RL5]
        key_read_req |=> (mem_wr_en && mem_wr_addr == $past(key_read_addr) &&
        mem_wr_data == $past(key_latch_ff)))
        else $error("key read wrote wrong word");

endmodule : vfd_digit_key_scan

// ### vfd_tube_keys.sv
// Far-side model: display tube plus key matrix returning on the digit strobes.
// Assumes the bench sets the pressed-key map; return lines have pull-downs.
`timescale 1ns/10ps
module vfd_tube_keys
    import vfd_scan_pkg::*;
(
    // Display drive from the block
    input wire logic [DIGIT_COUNT-1:0] digit_strobe_out,
    input wire logic [SEGMENT_COUNT-1:0] segment_out,
    // Pressed keys, one nibble per digit column
    input wire logic [DIGIT_COUNT-1:0][KEY_WIDTH-1:0] key_map,
    // Return lines to the block
    output logic [KEY_WIDTH-1:0] key_return_in
);
    ////////////////////////////////////////////////////////////////////////////
    // Matrix: a key only shows while its digit strobe is high
    always_comb
    begin
        key_return_in = '0;                  // Pull-downs hold idle lines low
        for (int k = 0; k < DIGIT_COUNT; k++)
        begin
            if (digit_strobe_out[k] === 1'b1)
            begin
                key_return_in |= key_map[k];
            end
        end
    end
endmodule : vfd_tube_keys

// ### vfd_digit_key_scan_test.sv
// Self-checking bench for the display scan and key latch.
// Assumes the package timing; the tube model answers the key returns.
`timescale 1ns/10ps
module vfd_digit_key_scan_test
    import vfd_scan_pkg::*;
;
    typedef struct
    {
        logic [DIGIT_COUNT-1:0] s;
        logic [SEGMENT_COUNT-1:0] g;
        int n;                             // Length of previous value, -1 ignored
    } scan_note_t;
    logic clk;
    logic arst_n;
    logic clock_halt_op;
    logic seg_wr_en;
    logic [DIGIT_SEL_W-1:0] seg_wr_digit;
    logic [SEGMENT_COUNT-1:0] seg_wr_data;
    logic [KEY_WIDTH-1:0] key_return_in;
    logic [DIGIT_SEL_W-1:0] key_slot_sel;
    logic key_read_req;
    logic [MEM_ADDR_W-1:0] key_read_addr;
    logic mem_wr_en;
    logic [MEM_ADDR_W-1:0] mem_wr_addr;
    logic [KEY_WIDTH-1:0] mem_wr_data;
    logic [DIGIT_COUNT-1:0] digit_strobe_out;
    logic [SEGMENT_COUNT-1:0] segment_out;
    logic [DIGIT_COUNT-1:0][KEY_WIDTH-1:0] key_map;
    logic [SEGMENT_COUNT-1:0] pat [DIGIT_COUNT];
    logic [KEY_WIDTH-1:0] old_key;
    scan_note_t scan_q[$];                 // Expected strobe changes
    logic [MEM_ADDR_W+KEY_WIDTH-1:0] mem_q[$]; // Expected memory writes
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int run_len = 0;
    logic watch_on = 1'b0;
    logic [DIGIT_COUNT-1:0] last_strobe;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and instances
    initial
    begin
        clk = 1'b0;
        forever #(CLK_PERIOD_NS/2) clk = ~clk;
    end
    vfd_digit_key_scan dut (.clk(clk), .arst_n(arst_n), .clock_halt_op(clock_halt_op),
        .seg_wr_en(seg_wr_en), .seg_wr_digit(seg_wr_digit), .seg_wr_data(seg_wr_data),
        .key_return_in(key_return_in), .key_slot_sel(key_slot_sel),
        .key_read_req(key_read_req), .key_read_addr(key_read_addr), .mem_wr_en(mem_wr_en),
        .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
        .digit_strobe_out(digit_strobe_out), .segment_out(segment_out));
    vfd_tube_keys tube (.digit_strobe_out(digit_strobe_out), .segment_out(segment_out),
        .key_map(key_map), .key_return_in(key_return_in));

    ////////////////////////////////////////////////////////////////////////////
    // Report and compare tasks
    task results;
        $display("errors %0d checked %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results
    task check_scan(input scan_note_t e, input logic [DIGIT_COUNT-1:0] s,
        input logic [SEGMENT_COUNT-1:0] g, input int n);
        samples_checked++;
        if (s !== e.s || g !== e.g || (e.n >= 0 && n != e.n))
        begin
            num_errors++;
            $display("mismatch scan exp %h/%h/%0d seen %h/%h/%0d", e.s, e.g, e.n, s, g, n);
        end
    endtask : check_scan
    task check_mem(input logic [MEM_ADDR_W+KEY_WIDTH-1:0] e, got);
        samples_checked++;
        if (got !== e)
        begin
            num_errors++;
            $display("mismatch mem_wr addr/data exp %h seen %h", e, got);
        end
    endtask : check_mem
    task note(input logic [DIGIT_COUNT-1:0] s, input logic [SEGMENT_COUNT-1:0] g, input int n);
        scan_note_t t;
        t.s = s;
        t.g = g;
        t.n = n;
        scan_q.push_back(t);
    endtask : note

    ////////////////////////////////////////////////////////////////////////////
    // Drivers: inputs change at the falling edge only
    task key_read(input int n, input logic [KEY_WIDTH-1:0] exp);
        logic [MEM_ADDR_W-1:0] a;
        for (int i = 0; i < n; i++)
        begin
            @(negedge clk);
            a = MEM_ADDR_W'($urandom);
            key_read_req = 1'b1;
            key_read_addr = a;
            mem_q.push_back({a, exp});
        end
        @(negedge clk);
        key_read_req = 1'b0;
    endtask : key_read
    task seg_write(input int d, input logic [SEGMENT_COUNT-1:0] v);
        @(negedge clk);
        seg_wr_en = 1'b1;
        seg_wr_digit = DIGIT_SEL_W'(d);
        seg_wr_data = v;
    endtask : seg_write
    task wait_level(input int k, input logic lvl);
        while (digit_strobe_out[k] !== lvl)
            @(negedge clk);
    endtask : wait_level

    ////////////////////////////////////////////////////////////////////////////
    // Hang guard, above the frame and a half the run needs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles > 40000)
        begin
            num_errors++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Watcher: each result takes the oldest note off its queue
    // Looks at the falling edge, half a cycle after the outputs settle
    always @(negedge clk)
    begin
        if (mem_wr_en === 1'b1)
        begin
            if (mem_q.size() == 0)
            begin
                num_errors++;
                $display("mismatch mem_wr_en exp 0 seen 1");
            end
            else
                check_mem(mem_q.pop_front(), {mem_wr_addr, mem_wr_data});
        end
        if (!watch_on)
        begin
            last_strobe = digit_strobe_out;
            run_len = 1;
        end
        else if (digit_strobe_out !== last_strobe)
        begin
            if (scan_q.size() == 0)
            begin
                num_errors++;
                $display("mismatch strobe exp %h seen %h", last_strobe, digit_strobe_out);
            end
            else
                check_scan(scan_q.pop_front(), digit_strobe_out, segment_out,
                    run_len);
            last_strobe = digit_strobe_out;
            run_len = 1;
        end
        else
            run_len++;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        arst_n = 1'b0;
        clock_halt_op = 1'b1;              // Hold the scan still while loading patterns
        seg_wr_en = 1'b0;
        seg_wr_digit = '0;
        seg_wr_data = '0;
        key_slot_sel = 3'h2;
        key_read_req = 1'b0;
        key_read_addr = '0;
        key_map = '0;
        void'($urandom(85604));
        repeat (12) @(negedge clk);
        check_scan('{s: '0, g: '0, n: -1}, digit_strobe_out, segment_out, 0);
        arst_n = 1'b1;
        repeat (2) @(negedge clk);
        key_read(2, KEY_LATCH_RST);
        seg_write(3, 8'h5a);               // Overwritten by the loop below
        for (int d = 0; d < DIGIT_COUNT; d++)
        begin
            pat[d] = SEGMENT_COUNT'($urandom);
            seg_write(d, pat[d]);
        end
        seg_write(7, 8'hff);               // Digit 7 must be ignored
        @(negedge clk);
        seg_wr_en = 1'b0;
        key_map = (DIGIT_COUNT*KEY_WIDTH)'($urandom);
        // One full frame, then digits 0..4 of the next
        for (int f = 0; f < 2; f++)
        begin
            for (int k = 0; k < DIGIT_COUNT; k++)
            begin
                if (f == 0 || k < 5)
                    note(DIGIT_COUNT'(1 << k), pat[k],
                        k > 0 ? SLOT_CYC : (f > 0 ? 3*SLOT_CYC : -1));
                if (f == 0 && k == 6)
                    note('0, '0, SLOT_CYC);
            end
        end
        watch_on = 1'b1;
        clock_halt_op = 1'b0;
        wait_level(2, 1'b1);
        wait_level(2, 1'b0);
        key_read(2, key_map[2]);
        old_key = key_map[2];
        key_map = (DIGIT_COUNT*KEY_WIDTH)'($urandom);
        key_slot_sel = 3'h6;
        key_read(1, old_key);
        wait_level(6, 1'b1);
        wait_level(6, 1'b0);
        key_read(1, key_map[6]);
        // Halt in mid-frame, then restart from slot 0
        wait_level(4, 1'b1);
        repeat (10) @(negedge clk);
        note('0, '0, -1);
        clock_halt_op = 1'b1;
        repeat (20) @(negedge clk);
        note(7'h01, pat[0], -1);
        note(7'h02, pat[1], SLOT_CYC);
        clock_halt_op = 1'b0;
        // Second reset in mid-run blanks the strobes
        wait_level(1, 1'b1);
        repeat (5) @(negedge clk);
        note('0, '0, -1);
        arst_n = 1'b0;
        repeat (3) @(negedge clk);
        // Release with halt low: scan restarts at digit 0, patterns and latch cleared
        note(7'h01, '0, -1);
        arst_n = 1'b1;
        repeat (8) @(negedge clk);
        key_read(1, KEY_LATCH_RST);
        repeat (2) @(negedge clk);
        if (scan_q.size() != 0 || mem_q.size() != 0)
        begin
            num_errors++;
            $display("mismatch queues exp 0 seen %0d", scan_q.size() + mem_q.size());
        end
        results();
    end
endmodule : vfd_digit_key_scan_test
